// ---- pkg/bmwd_pkg.sv ----
// package: register map, field layout and types for the memory window decode
package bmwd_pkg;
	// register byte offsets
	localparam logic [7:0] MEM_WIN_OFS     = 8'h20;
	localparam logic [7:0] PF_WIN_OFS      = 8'h24;
	localparam logic [7:0] PF_BOT_HI_OFS   = 8'h28;
	localparam logic [7:0] PF_TOP_HI_OFS   = 8'h2C;
	localparam logic [7:0] CMP_CTRL_OFS    = 8'h40;
	localparam logic [7:0] CMP_STAT_OFS    = 8'h44;
	// field layout
	localparam int         FIELD_W         = 12;
	localparam int         ADDR_W          = 64;
	localparam int         OFS_W           = 8;
	localparam logic [3:0] ADDR64_IND      = 4'h1;
	localparam logic [3:0] LOW_NIBBLE_ZERO = 4'h0;
	localparam logic [19:0] LOW_ONES       = 20'hFFFFF;
	localparam logic [19:0] LOW_ZEROS      = 20'h00000;
	localparam logic [11:0] FIELD_RST      = 12'h000;
	localparam logic [31:0] WORD_RST       = 32'h00000000;
	localparam logic [31:0] UNMAPPED_DATA  = 32'h00000000;
	// forwarding enable and hit counter
	localparam logic        FWD_EN_RST     = 1'b1;
	localparam logic [15:0] CNT_RST        = 16'h0000;
	localparam logic [15:0] CNT_MAX        = 16'hFFFF;
	localparam logic [15:0] CNT_STEP       = 16'h0001;
	// decode request: address and whether it comes from the primary side
	typedef struct packed {
		logic        valid;
		logic        from_primary;
		logic [63:0] addr;
	} bmwd_req_s;
	// decode answer
	typedef struct packed {
		logic hit_mem;
		logic hit_pf;
		logic forward;
	} bmwd_res_s;
endpackage

// ---- verilog/bmwd_range_cmp.sv ----
// range comparator: inclusive bottom..top test on a 64-bit address
`timescale 1ns/10ps
`default_nettype none
module bmwd_range_cmp (
	input  wire logic [63:0] i_addr,
	input  wire logic [63:0] i_bottom,
	input  wire logic [63:0] i_top,
	output logic             o_hit
);
	// inclusive at both ends; empty when bottom is above top
	assign o_hit = (i_addr >= i_bottom) && (i_addr <= i_top);
endmodule
`default_nettype wire

// ---- verilog/bmwd_top.sv ----
// memory window registers, wishbone slave and forwarding decode
`timescale 1ns/10ps
`default_nettype none
module bmwd_top (
	input  wire logic                I_CLK,
	input  wire logic                I_SRST,
	input  wire logic                I_WB_CYC,
	input  wire logic                I_WB_STB,
	input  wire logic                I_WB_WE,
	input  wire logic [7:0]          I_WB_ADR,
	input  wire logic [3:0]          I_WB_SEL,
	input  wire logic [31:0]         I_WB_DAT,
	output logic      [31:0]         O_WB_DAT,
	output logic                     O_WB_ACK,
	input  wire bmwd_pkg::bmwd_req_s I_REQ,
	output bmwd_pkg::bmwd_res_s      O_RES
);
	// register state
	logic [11:0] mem_bot_reg;
	logic [11:0] mem_top_reg;
	logic [11:0] pf_bot_reg;
	logic [11:0] pf_top_reg;
	logic [31:0] pf_bot_hi_reg;
	logic [31:0] pf_top_hi_reg;
	logic        fwd_en_reg;
	logic [15:0] fwd_cnt_reg;
	logic        acc;
	logic        wr;
	logic [31:0] rd_next;
	logic [63:0] mem_bot;
	logic [63:0] mem_top;
	logic [63:0] pf_bot;
	logic [63:0] pf_top;
	logic        hit_mem;
	logic        hit_pf;
	logic [31:0] wmask;

	// one-cycle answer; ack drops the cycle after it is given
	assign acc = I_WB_CYC && I_WB_STB && !O_WB_ACK;
	assign wr  = acc && I_WB_WE;
	assign wmask = {{8{I_WB_SEL[3]}}, {8{I_WB_SEL[2]}}, {8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};

	// wishbone ack
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			O_WB_ACK <= 1'b0;
		end else begin
			O_WB_ACK <= acc;
		end
	end

	// memory window bottom and top fields; low nibbles never stored
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			mem_bot_reg <= bmwd_pkg::FIELD_RST;
			mem_top_reg <= bmwd_pkg::FIELD_RST;
		end else if (wr && I_WB_ADR == bmwd_pkg::MEM_WIN_OFS) begin
			if (I_WB_SEL[0]) mem_bot_reg[3:0]  <= I_WB_DAT[7:4];
			if (I_WB_SEL[1]) mem_bot_reg[11:4] <= I_WB_DAT[15:8];
			if (I_WB_SEL[2]) mem_top_reg[3:0]  <= I_WB_DAT[23:20];
			if (I_WB_SEL[3]) mem_top_reg[11:4] <= I_WB_DAT[31:24];
		end
	end

	// prefetch window fields; indicator nibbles are constants
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			pf_bot_reg <= bmwd_pkg::FIELD_RST;
			pf_top_reg <= bmwd_pkg::FIELD_RST;
		end else if (wr && I_WB_ADR == bmwd_pkg::PF_WIN_OFS) begin
			if (I_WB_SEL[0]) pf_bot_reg[3:0]  <= I_WB_DAT[7:4];
			if (I_WB_SEL[1]) pf_bot_reg[11:4] <= I_WB_DAT[15:8];
			if (I_WB_SEL[2]) pf_top_reg[3:0]  <= I_WB_DAT[23:20];
			if (I_WB_SEL[3]) pf_top_reg[11:4] <= I_WB_DAT[31:24];
		end
	end

	// upper address words, byte-lane writes
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			pf_bot_hi_reg <= bmwd_pkg::WORD_RST;
			pf_top_hi_reg <= bmwd_pkg::WORD_RST;
		end else begin
			if (wr && I_WB_ADR == bmwd_pkg::PF_BOT_HI_OFS) begin
				pf_bot_hi_reg <= (pf_bot_hi_reg & ~wmask) | (I_WB_DAT & wmask);
			end
			if (wr && I_WB_ADR == bmwd_pkg::PF_TOP_HI_OFS) begin
				pf_top_hi_reg <= (pf_top_hi_reg & ~wmask) | (I_WB_DAT & wmask);
			end
		end
	end

	// forwarding enable; on from reset so a programmed window works without a second write
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			fwd_en_reg <= bmwd_pkg::FWD_EN_RST;
		end else if (wr && I_WB_ADR == bmwd_pkg::CMP_CTRL_OFS && I_WB_SEL[0]) begin
			fwd_en_reg <= I_WB_DAT[0];
		end
	end

	// window-hit counter, counting only while forwarding is enabled; saturates so software never sees a wrap
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			fwd_cnt_reg <= bmwd_pkg::CNT_RST;
		end else if (wr && I_WB_ADR == bmwd_pkg::CMP_STAT_OFS) begin
			fwd_cnt_reg <= bmwd_pkg::CNT_RST;
		end else if (I_REQ.valid && (hit_mem || hit_pf) && fwd_en_reg && fwd_cnt_reg != bmwd_pkg::CNT_MAX) begin
			fwd_cnt_reg <= fwd_cnt_reg + bmwd_pkg::CNT_STEP;
		end
	end

	// read mux; unmapped offsets read zero but still ack
	always_comb begin
		rd_next = bmwd_pkg::UNMAPPED_DATA;
		unique case (I_WB_ADR)
			bmwd_pkg::MEM_WIN_OFS: rd_next = {mem_top_reg, bmwd_pkg::LOW_NIBBLE_ZERO,
				mem_bot_reg, bmwd_pkg::LOW_NIBBLE_ZERO};
			bmwd_pkg::PF_WIN_OFS: rd_next = {pf_top_reg, bmwd_pkg::ADDR64_IND,
				pf_bot_reg, bmwd_pkg::ADDR64_IND};
			bmwd_pkg::PF_BOT_HI_OFS: rd_next = pf_bot_hi_reg;
			bmwd_pkg::PF_TOP_HI_OFS: rd_next = pf_top_hi_reg;
			bmwd_pkg::CMP_CTRL_OFS: rd_next = {31'h00000000, fwd_en_reg};
			bmwd_pkg::CMP_STAT_OFS: rd_next = {16'h0000, fwd_cnt_reg};
			default: rd_next = bmwd_pkg::UNMAPPED_DATA;
		endcase
	end

	// read data register
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			O_WB_DAT <= bmwd_pkg::UNMAPPED_DATA;
		end else if (acc && !I_WB_WE) begin
			O_WB_DAT <= rd_next;
		end
	end

	// window bounds; memory window is 32-bit only
	assign mem_bot = {32'h00000000, mem_bot_reg, bmwd_pkg::LOW_ZEROS};
	assign mem_top = {32'h00000000, mem_top_reg, bmwd_pkg::LOW_ONES};
	assign pf_bot  = {pf_bot_hi_reg, pf_bot_reg, bmwd_pkg::LOW_ZEROS};
	assign pf_top  = {pf_top_hi_reg, pf_top_reg, bmwd_pkg::LOW_ONES};

	bmwd_range_cmp u_mem_cmp (
		.i_addr   (I_REQ.addr),
		.i_bottom (mem_bot),
		.i_top    (mem_top),
		.o_hit    (hit_mem)
	);

	bmwd_range_cmp u_pf_cmp (
		.i_addr   (I_REQ.addr),
		.i_bottom (pf_bot),
		.i_top    (pf_top),
		.o_hit    (hit_pf)
	);

	// registered decode: primary hits go downstream, secondary misses go upstream
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			O_RES <= '0;
		end else begin
			O_RES.hit_mem <= I_REQ.valid && hit_mem;
			O_RES.hit_pf  <= I_REQ.valid && hit_pf;
			O_RES.forward <= I_REQ.valid && fwd_en_reg &&
				(I_REQ.from_primary ? (hit_mem || hit_pf) : !(hit_mem || hit_pf));
		end
	end

	a_ack_one_cycle: assert property (@(posedge I_CLK) disable iff (I_SRST)
		O_WB_ACK |=> !O_WB_ACK) else $error("ack held two cycles");
	a_ack_follows_req: assert property (@(posedge I_CLK) disable iff (I_SRST)
		(I_WB_CYC && I_WB_STB && !O_WB_ACK) |=> O_WB_ACK) else $error("ack missing");
	a_mem_nibble_zero: assert property (@(posedge I_CLK) disable iff (I_SRST)
		(O_WB_ACK && !$past(I_WB_WE) && $past(I_WB_ADR) == bmwd_pkg::MEM_WIN_OFS)
		|-> (O_WB_DAT[19:16] == 4'h0 && O_WB_DAT[3:0] == 4'h0)) else $error("mem nibble nonzero");
	a_pf_ind_one: assert property (@(posedge I_CLK) disable iff (I_SRST)
		(O_WB_ACK && !$past(I_WB_WE) && $past(I_WB_ADR) == bmwd_pkg::PF_WIN_OFS)
		|-> (O_WB_DAT[19:16] == 4'h1 && O_WB_DAT[3:0] == 4'h1)) else $error("pf indicator wrong");
	a_mem_top_incl: assert property (@(posedge I_CLK) disable iff (I_SRST)
		(I_REQ.valid && I_REQ.addr == mem_top && mem_bot <= mem_top) |=> O_RES.hit_mem)
		else $error("mem top not inclusive");
	a_mem_above_top: assert property (@(posedge I_CLK) disable iff (I_SRST)
		(I_REQ.valid && I_REQ.addr > mem_top) |=> !O_RES.hit_mem) else $error("hit above mem top");
	a_pf_bottom_incl: assert property (@(posedge I_CLK) disable iff (I_SRST)
		(I_REQ.valid && I_REQ.addr == pf_bot && pf_bot <= pf_top) |=> O_RES.hit_pf)
		else $error("pf bottom not inclusive");
	a_pf_below_bot: assert property (@(posedge I_CLK) disable iff (I_SRST)
		(I_REQ.valid && I_REQ.addr < pf_bot) |=> !O_RES.hit_pf) else $error("hit below pf bottom");
	// reset values, checked the cycle after a reset edge so no history is needed; then no hit just below the memory bottom
	a_hi_bot_reset: assert property (@(posedge I_CLK)
		I_SRST |=> pf_bot_hi_reg == bmwd_pkg::WORD_RST) else $error("pf bottom high not reset");
	a_hi_top_reset: assert property (@(posedge I_CLK)
		I_SRST |=> pf_top_hi_reg == bmwd_pkg::WORD_RST) else $error("pf top high not reset");
	a_fwd_en_reset: assert property (@(posedge I_CLK)
		I_SRST |=> fwd_en_reg == bmwd_pkg::FWD_EN_RST) else $error("forward enable not reset");
	a_mem_bot_zero: assert property (@(posedge I_CLK) disable iff (I_SRST)
		(I_REQ.valid && mem_bot_reg != 12'h000 && I_REQ.addr == mem_bot - 64'h1) |=> !O_RES.hit_mem)
		else $error("hit below mem bottom");

	// prefetch top edge, 32-bit memory window, idle answer and counter clear
	a_pf_top_incl: assert property (@(posedge I_CLK) disable iff (I_SRST)
		(I_REQ.valid && I_REQ.addr == pf_top && pf_bot <= pf_top) |=> O_RES.hit_pf)
		else $error("pf top not inclusive");
	a_mem_hi_miss: assert property (@(posedge I_CLK) disable iff (I_SRST)
		(I_REQ.valid && I_REQ.addr[63:32] != 32'h00000000) |=> !O_RES.hit_mem)
		else $error("mem hit with upper address set");
	a_res_idle_zero: assert property (@(posedge I_CLK) disable iff (I_SRST)
		!I_REQ.valid |=> (O_RES == 3'h0)) else $error("decode answer without request");
	a_fwd_off_quiet: assert property (@(posedge I_CLK) disable iff (I_SRST)
		!fwd_en_reg |=> !O_RES.forward) else $error("forward while disabled");
	a_cnt_clear_wins: assert property (@(posedge I_CLK) disable iff (I_SRST)
		(wr && I_WB_ADR == bmwd_pkg::CMP_STAT_OFS) |=> (fwd_cnt_reg == bmwd_pkg::CNT_RST))
		else $error("count not cleared");
endmodule
`default_nettype wire

// ---- dv/bmwd_agent_model.sv ----
// far-side agent model: one decode request per cycle when asked
`timescale 1ns/10ps
`default_nettype none
module bmwd_agent_model (
	input  wire logic           i_clk,
	input  wire logic           i_go,
	input  wire logic           i_prim,
	input  wire logic [63:0]    i_addr,
	output var bmwd_pkg::bmwd_req_s o_req
);
	initial o_req = '0;
	// idle address is inverted, not held, so a stale hit cannot pass
	always @(posedge i_clk) begin
		o_req.valid <= i_go;
		o_req.from_primary <= i_go ? i_prim : ~o_req.from_primary;
		o_req.addr <= i_go ? i_addr : ~o_req.addr;
	end
endmodule
`default_nettype wire

// ---- dv/tb_bmwd_top.sv ----
// self-checking bench for the memory window decode
`timescale 1ns/10ps
`default_nettype none
module tb_bmwd_top;
	logic I_CLK = 0, I_SRST = 1, cyc = 0, stb = 0, we = 0, go = 0, prim = 0, vd = 0, O_WB_ACK, en;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wd = 32'h0, O_WB_DAT, bhi, thi, rdq[$];
	logic [63:0] ga = 64'h0, edges[10];
	logic [11:0] mb, mt, pb, pt;
	logic [2:0] dq[$];
	int seed = 32'he22e, failures = 0, checks = 0, hits = 0;
	logic [31:0] rnd;
	bmwd_pkg::bmwd_req_s rq;
	bmwd_pkg::bmwd_res_s O_RES;
	always #10 I_CLK = ~I_CLK;
	bmwd_agent_model bmwd_agent_model_inst (.i_clk(I_CLK), .i_go(go), .i_prim(prim), .i_addr(ga), .o_req(rq));
	bmwd_top bmwd_top_inst (.I_CLK(I_CLK), .I_SRST(I_SRST), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
		.I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wd), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK),
		.I_REQ(rq), .O_RES(O_RES));
	task end_sim;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
		checks++;
		if (g !== e) begin
			failures++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
		end
	endtask
	// one classic cycle; reads note their expectation first
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		int n;
		if (!w)
			rdq.push_back(e);
		@(posedge I_CLK);
		{cyc, stb, we, adr, wd, sel} <= {2'b11, w, a, d, 4'hF};
		n = 0;
		do begin
			@(posedge I_CLK);
			n++;
		end while (O_WB_ACK !== 1'b1 && n < 20);
		if (O_WB_ACK !== 1'b1) begin
			failures++;
			end_sim();
		end
		{cyc, stb} <= 2'b00;
	endtask
	// expected answer from the shadow of the programmed windows
	function automatic logic [2:0] exp_res(input logic p, input logic [63:0] a);
		logic hm, hp;
		hm = a[63:32] == 0 && a[31:20] >= mb && a[31:20] <= mt;
		hp = a >= {bhi, pb, 20'h0} && a <= {thi, pt, 20'hFFFFF};
		return {hm, hp, en & (p ? hm | hp : !(hm | hp))};
	endfunction
	task automatic dec(input logic p, input logic [63:0] a);
		logic [2:0] e;
		e = exp_res(p, a);
		dq.push_back(e);
		if (en && (e[2] || e[1]))
			hits++;
		@(posedge I_CLK);
		{go, prim, ga} <= {1'b1, p, a};
	endtask
	task automatic dec_stop;
		@(posedge I_CLK);
		go <= 0;
		repeat (3) @(posedge I_CLK);
	endtask
	// answers are taken in order off the queues as they appear
	always @(posedge I_CLK) begin
		if (O_WB_ACK === 1'b1 && we === 1'b0)
			cmp(O_WB_DAT, rdq.pop_front(), "read");
		if (vd === 1'b1)
			cmp({29'h0, O_RES}, {29'h0, dq.pop_front()}, "decode");
		vd = rq.valid;
	end
	initial begin
		edges = '{64'h10000000, 64'h0FFFFFFF, 64'h1FFFFFFF, 64'h20000000, 64'h180000000,
			64'h17FFFFFFF, 64'h18FFFFFFF, 64'h190000000, 64'h110000000, 64'h80000000};
		repeat (5) @(posedge I_CLK);
		I_SRST <= 0;
		wb(0, 8'h20, 0, 32'h0);
		wb(0, 8'h24, 0, 32'h00010001);
		wb(0, 8'h28, 0, 32'h0);
		wb(0, 8'h2C, 0, 32'h0);
		wb(0, 8'h40, 0, 32'h1);
		wb(0, 8'h44, 0, 32'h0);
		$display("test reset values done");
		wb(1, 8'h20, 32'hFFFFFFFF, 0);
		wb(0, 8'h20, 0, 32'hFFF0FFF0);
		wb(1, 8'h24, 32'hFFFFFFFF, 0);
		wb(0, 8'h24, 0, 32'hFFF1FFF1);
		wb(1, 8'h30, 32'hFFFFFFFF, 0);
		wb(0, 8'h30, 0, 32'h0);
		$display("test read-only bits done");
		{mb, mt, pb, pt} = {12'h100, 12'h1FF, 12'h800, 12'h8FF};
		{bhi, thi, en} = {32'h1, 32'h1, 1'b1};
		wb(1, 8'h20, {mt, 4'h0, mb, 4'h0}, 0);
		wb(1, 8'h24, {pt, 4'h0, pb, 4'h0}, 0);
		wb(1, 8'h28, bhi, 0);
		wb(1, 8'h2C, thi, 0);
		wb(0, 8'h28, 0, 32'h1);
		wb(0, 8'h2C, 0, 32'h1);
		for (int i = 0; i < 20; i++)
			dec(i[0], edges[i >> 1]);
		for (int i = 0; i < 40; i++) begin
			rnd = $random(seed);
			dec(rnd[0], {31'h0, rnd[1], rnd[2] ? 4'h8 : 4'h1, 28'($random(seed))});
		end
		dec_stop();
		wb(0, 8'h44, 0, {16'h0, 16'(hits)});
		wb(1, 8'h44, 0, 0);
		wb(0, 8'h44, 0, 32'h0);
		hits = 0;
		$display("test window edges done");
		en = 0;
		wb(1, 8'h40, 0, 0);
		wb(0, 8'h40, 0, 32'h0);
		dec(1, 64'h10000000);
		dec(0, 64'h0);
		dec_stop();
		wb(0, 8'h44, 0, 32'h0);
		$display("test forward off done");
		@(posedge I_CLK);
		I_SRST <= 1;
		repeat (2) @(posedge I_CLK);
		I_SRST <= 0;
		{mb, mt, pb, pt} = '0;
		{bhi, thi, en} = {64'h0, 1'b1};
		wb(0, 8'h40, 0, 32'h1);
		wb(0, 8'h24, 0, 32'h00010001);
		wb(0, 8'h2C, 0, 32'h0);
		dec(1, 64'h000FFFFF);
		dec(0, 64'h00100000);
		dec_stop();
		$display("test mid-run reset done");
		end_sim();
	end
endmodule
`default_nettype wire
